// ### logic/dwhsp_pkg.sv
package dwhsp_pkg;
  localparam int DATA_WIDTH = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int MCLK_PERIOD_NS = 8;
  localparam int SCLK_PERIOD_NS = 64;
  localparam int SCLK_PERIOD_CYC = SCLK_PERIOD_NS / MCLK_PERIOD_NS;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_CYC / 2;
  localparam int CMD_CLOCKS_1BIT = 7;
  localparam int BYTE_CLOCKS_1BIT = 8;
  localparam logic [2:0] CMD_LAST = 3'(CMD_CLOCKS_1BIT - 1);
  localparam logic [2:0] BYTE_LAST_1BIT = 3'(BYTE_CLOCKS_1BIT - 1);
  localparam int POS_CMD3 = 0;
  localparam int POS_W2 = 1;
  localparam int POS_W4 = 2;
  localparam int POS_CMD2 = 3;
  localparam int POS_W8 = 4;
  localparam int POS_CMD1 = 5;
  localparam int POS_CMD0 = 6;
  localparam logic [3:0] CMD_WRITE = 4'h0;
  localparam logic [3:0] CMD_READ = 4'h1;
  localparam logic ACK_LVL = 1'b0;
  localparam logic NAK_LVL = 1'b1;
  localparam logic STAT_READY = 1'b0;
  localparam logic STAT_BUSY = 1'b1;
  localparam logic RESET_SCLK = 1'b1;
  localparam logic RESET_SS_N = 1'b1;
  localparam logic [7:0] RESET_LINES = 8'hff;

  typedef logic [1:0] dwhsp_width_type;
  localparam dwhsp_width_type WID_1 = 2'h0;
  localparam dwhsp_width_type WID_2 = 2'h1;
  localparam dwhsp_width_type WID_4 = 2'h2;
  localparam dwhsp_width_type WID_8 = 2'h3;

  function automatic logic [7:0] width_mask(dwhsp_width_type w);
    logic [7:0] m;
    m = 8'hff;
    case (w)
      WID_1: m = 8'h01;
      WID_2: m = 8'h03;
      WID_4: m = 8'h0f;
      default: m = 8'hff;
    endcase
    return m;
  endfunction

  // Chunks arrive low part first, so new bits enter at the top
  function automatic logic [7:0] shift_in(logic [7:0] sr, logic [7:0] d,
                                          dwhsp_width_type w);
    logic [7:0] r;
    r = d;
    case (w)
      WID_1: r = {d[0], sr[7:1]};
      WID_2: r = {d[1:0], sr[7:2]};
      WID_4: r = {d[3:0], sr[7:4]};
      default: r = d;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] shift_out(logic [7:0] sr,
                                           dwhsp_width_type w);
    logic [7:0] r;
    r = 8'h00;
    case (w)
      WID_1: r = {1'b0, sr[7:1]};
      WID_2: r = {2'h0, sr[7:2]};
      WID_4: r = {4'h0, sr[7:4]};
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  function automatic dwhsp_width_type decode_width(logic [7:0] s);
    dwhsp_width_type w;
    w = WID_1;
    if (!(&s[7:4])) w = WID_8;
    else if (!(&s[3:2])) w = WID_4;
    else if (!s[1]) w = WID_2;
    return w;
  endfunction

  function automatic logic [3:0] cmd_of(logic [7:0] s);
    return {s[POS_CMD3], s[POS_CMD2], s[POS_CMD1], s[POS_CMD0]};
  endfunction

  function automatic logic [7:0] cmd_word(logic [3:0] c,
                                          dwhsp_width_type w);
    logic [7:0] r;
    r = 8'hff;
    r[POS_CMD3] = c[3];
    r[POS_CMD2] = c[2];
    r[POS_CMD1] = c[1];
    r[POS_CMD0] = c[0];
    r[POS_W2] = (w != WID_2);
    r[POS_W4] = (w != WID_4);
    r[POS_W8] = (w != WID_8);
    return r;
  endfunction
endpackage

// ### logic/dwhsp_link_if.sv
`timescale 1ns/1ps
interface dwhsp_link_if;
  logic ss_n;
  logic sclk;
  logic miso_out;
  logic miso_oe;
  logic miso;
  logic [7:0] m_data_out;
  logic [7:0] m_data_oe;
  logic [7:0] s_data_out;
  logic [7:0] s_data_oe;
  logic [7:0] bidir_data_lines;

  // Pull-ups make every undriven line read as one
  assign bidir_data_lines = (m_data_out & m_data_oe)
                          | (s_data_out & s_data_oe & ~m_data_oe)
                          | ~(m_data_oe | s_data_oe);
  assign miso = miso_oe ? miso_out : 1'b1;

  modport master
  (
    output ss_n,
    output sclk,
    output m_data_out,
    output m_data_oe,
    input miso,
    input bidir_data_lines
  );
  modport slave
  (
    input ss_n,
    input sclk,
    output miso_out,
    output miso_oe,
    output s_data_out,
    output s_data_oe,
    input bidir_data_lines
  );
endinterface

// ### logic/dwhsp_fifo.sv
`timescale 1ns/1ps
module dwhsp_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != FULL);
  assign out_valid = (count != '0);
  assign out_data = mem[rptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wptr] <= in_data;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wptr <= (wptr == LAST) ? '0 : wptr + 1'b1;
      if (pop)
        rptr <= (rptr == LAST) ? '0 : rptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule

// ### logic/dwhsp_slave.sv
`timescale 1ns/1ps
// Function
// - Data lines run 1, 2, 4 or 8 wide
// - Idle: write status line 0, read status MISO
// - Input switches idle status driving off
// - Command and width phase, then data phase
// - ACK or NAK on MISO per byte
// - Master may burst; aborts on NAK
// - First rise samples all eight lines
// - Width decode by priority, 8 then 4, 2
// - Undriven lines read as one
// - Command bits at positions 0, 3, 5, 6
// - Release line 0 once select goes low
// - 1-bit command 7 clocks, then turnaround
// - 1-bit byte takes 8 clocks
// - ACK or NAK held for each whole byte
// - Master releases line 0 before deselect
// - After read, line 0 goes straight to status
// - Data phase only while select is low
module dwhsp_slave
(
  input wire logic mclk,
  input wire logic reset_n,
  dwhsp_link_if.slave link,
  input wire logic status_en,
  output logic [7:0] wr_tdata,
  output logic wr_tvalid,
  input wire logic wr_tready,
  input wire logic [7:0] rd_tdata,
  input wire logic rd_tvalid,
  output logic rd_tready
);
  typedef enum logic [1:0] {S_IDLE, S_CMD, S_TURN, S_DATA}
    dwhsp_sstate_type;

  dwhsp_sstate_type state;
  logic ss_s1;
  logic ss_s2;
  logic ck_s1;
  logic ck_s2;
  logic ck_s3;
  logic [7:0] d_s1;
  logic [7:0] d_s2;
  logic ss_act;
  logic rise;
  dwhsp_pkg::dwhsp_width_type width;
  logic [7:0] samp;
  logic [3:0] cmd;
  logic [2:0] cnt;
  logic [2:0] last;
  logic [2:0] cpos;
  logic [2:0] cmd_end;
  logic decide;
  logic ok;
  logic next_ok;
  logic is_wr;
  logic is_rd;
  logic [7:0] wsr;
  logic [7:0] rsr;
  logic push_v;
  logic [7:0] push_d;
  logic fifo_in_ready;
  logic [7:0] mask;
  logic miso_q;
  logic miso_oe_q;
  logic [7:0] out_q;
  logic [7:0] oe_q;

  // Link pins come from another clock domain
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ss_s1 <= dwhsp_pkg::RESET_SS_N;
      ss_s2 <= dwhsp_pkg::RESET_SS_N;
      ck_s1 <= dwhsp_pkg::RESET_SCLK;
      ck_s2 <= dwhsp_pkg::RESET_SCLK;
      ck_s3 <= dwhsp_pkg::RESET_SCLK;
      d_s1 <= dwhsp_pkg::RESET_LINES;
      d_s2 <= dwhsp_pkg::RESET_LINES;
    end
    else
    begin
      ss_s1 <= link.ss_n;
      ss_s2 <= ss_s1;
      ck_s1 <= link.sclk;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      d_s1 <= link.bidir_data_lines;
      d_s2 <= d_s1;
    end
  end

  assign ss_act = ~ss_s2;
  assign rise = ck_s2 & ~ck_s3 & ss_act;
  assign is_wr = (cmd == dwhsp_pkg::CMD_WRITE);
  assign is_rd = (cmd == dwhsp_pkg::CMD_READ);
  assign last = dwhsp_pkg::BYTE_LAST_1BIT >> width;
  assign mask = dwhsp_pkg::width_mask(width);
  assign cpos = cnt << width;
  assign cmd_end = (width == dwhsp_pkg::WID_1) ? dwhsp_pkg::CMD_LAST
                                               : last;
  // Push on the last edge itself so the next decision sees the new level
  assign push_v = rise && state == S_DATA && is_wr && ok && cnt == last;
  assign push_d = dwhsp_pkg::shift_in(wsr, d_s2, width);
  // Unknown commands get NAK on every byte
  assign next_ok = is_wr ? fifo_in_ready : (is_rd & rd_tvalid);
  assign rd_tready = decide & is_rd & rd_tvalid;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= S_IDLE;
      width <= dwhsp_pkg::WID_1;
      samp <= dwhsp_pkg::RESET_LINES;
      cmd <= dwhsp_pkg::CMD_WRITE;
      cnt <= 3'h0;
      decide <= 1'b0;
    end
    else if (!ss_act)
    begin
      state <= S_IDLE;
      decide <= 1'b0;
    end
    else
    begin
      decide <= 1'b0;
      if (rise)
      begin
        unique case (state)
          S_IDLE:
          begin
            samp <= d_s2;
            width <= dwhsp_pkg::decode_width(d_s2);
            cnt <= 3'h1;
            if (dwhsp_pkg::decode_width(d_s2) == dwhsp_pkg::WID_8)
              state <= S_TURN;
            else
              state <= S_CMD;
          end
          S_CMD:
          begin
            // Narrow modes carry the word in chunks, low chunk first
            samp <= (samp & ~(mask << cpos)) | ((d_s2 & mask) << cpos);
            cnt <= cnt + 3'h1;
            if (cnt == cmd_end)
              state <= S_TURN;
          end
          S_TURN:
          begin
            cmd <= dwhsp_pkg::cmd_of(samp);
            cnt <= 3'h0;
            decide <= 1'b1;
            state <= S_DATA;
          end
          S_DATA:
          begin
            if (cnt == last)
            begin
              cnt <= 3'h0;
              decide <= 1'b1;
            end
            else
              cnt <= cnt + 3'h1;
          end
        endcase
      end
    end
  end

  // Decision waits a cycle so the FIFO level includes the last push
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      ok <= 1'b0;
    else if (!ss_act)
      ok <= 1'b0;
    else if (decide)
      ok <= next_ok;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      wsr <= 8'h00;
    else if (rise && state == S_DATA && is_wr && ok)
      wsr <= dwhsp_pkg::shift_in(wsr, d_s2, width);
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      rsr <= 8'h00;
    else if (decide && is_rd)
      rsr <= dwhsp_pkg::shift_out(rd_tdata, width);
    else if (rise && state == S_DATA && is_rd && cnt != last)
      rsr <= dwhsp_pkg::shift_out(rsr, width);
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_q <= 8'h00;
      oe_q <= 8'h00;
      miso_q <= dwhsp_pkg::STAT_BUSY;
      miso_oe_q <= 1'b0;
    end
    else if (!ss_act)
    begin
      // Read data hands over to status with no gap
      oe_q <= {7'h00, status_en};
      out_q <= {7'h00, fifo_in_ready ? dwhsp_pkg::STAT_READY
                                     : dwhsp_pkg::STAT_BUSY};
      miso_oe_q <= status_en;
      miso_q <= rd_tvalid ? dwhsp_pkg::STAT_READY
                          : dwhsp_pkg::STAT_BUSY;
    end
    else if (state == S_IDLE)
    begin
      oe_q <= 8'h00;
      miso_oe_q <= 1'b1;
      miso_q <= dwhsp_pkg::NAK_LVL;
    end
    else if (decide)
    begin
      miso_q <= next_ok ? dwhsp_pkg::ACK_LVL
                        : dwhsp_pkg::NAK_LVL;
      if (is_rd)
      begin
        oe_q <= mask;
        out_q <= rd_tdata & mask;
      end
    end
    else if (rise && state == S_DATA && is_rd && cnt != last)
      out_q <= rsr & mask;
  end

  assign link.s_data_out = out_q;
  assign link.s_data_oe = oe_q;
  assign link.miso_out = miso_q;
  assign link.miso_oe = miso_oe_q;

  dwhsp_fifo
  #(
    .WIDTH(dwhsp_pkg::DATA_WIDTH),
    .DEPTH(dwhsp_pkg::FIFO_DEPTH)
  )
  u_wr_fifo
  (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(push_v),
    .in_ready(fifo_in_ready),
    .in_data(push_d),
    .out_valid(wr_tvalid),
    .out_ready(wr_tready),
    .out_data(wr_tdata)
  );
endmodule

// ### logic/dwhsp_master.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module dwhsp_master
(
  input wire logic mclk,
  input wire logic reset_n,
  dwhsp_link_if.master link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [3:0] req_cmd,
  input wire logic [1:0] req_width,
  input wire logic [3:0] req_len,
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic nak,
  output logic wbuf_ready,
  output logic rbuf_ready
);
  typedef enum logic [2:0] {M_IDLE, M_CMD, M_TURN, M_DATA, M_STOP}
    dwhsp_mstate_type;
  localparam logic [2:0] PH_FALL = 3'h0;
  localparam logic [2:0] PH_RISE = 3'(dwhsp_pkg::SCLK_HALF_CYC);
  localparam logic [2:0] PH_END = 3'(dwhsp_pkg::SCLK_PERIOD_CYC - 1);
  // First fall comes three cycles after select, never a rise first
  localparam logic [2:0] PH_START = 3'(dwhsp_pkg::SCLK_PERIOD_CYC - 2);

  dwhsp_mstate_type state;
  logic ms_s1;
  logic ms_s2;
  logic [7:0] md_s1;
  logic [7:0] md_s2;
  logic [2:0] ph;
  logic [2:0] cnt;
  logic [2:0] last;
  logic [2:0] cpos;
  logic [2:0] cmd_end;
  dwhsp_pkg::dwhsp_width_type width;
  logic [3:0] cmd;
  logic [3:0] len;
  logic [3:0] nbytes;
  logic [3:0] next_nbytes;
  logic [7:0] sr;
  logic [7:0] word;
  logic [7:0] mask;
  logic fall;
  logic rise;
  logic is_wr;
  logic is_rd;
  logic nak_now;
  logic byte_end;
  logic more;
  logic stop;
  logic sclk_q;
  logic ss_n_q;
  logic [7:0] out_q;
  logic [7:0] oe_q;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ms_s1 <= dwhsp_pkg::NAK_LVL;
      ms_s2 <= dwhsp_pkg::NAK_LVL;
      md_s1 <= dwhsp_pkg::RESET_LINES;
      md_s2 <= dwhsp_pkg::RESET_LINES;
    end
    else
    begin
      ms_s1 <= link.miso;
      ms_s2 <= ms_s1;
      md_s1 <= link.bidir_data_lines;
      md_s2 <= md_s1;
    end
  end

  assign is_wr = (cmd == dwhsp_pkg::CMD_WRITE);
  assign is_rd = (cmd == dwhsp_pkg::CMD_READ);
  assign last = dwhsp_pkg::BYTE_LAST_1BIT >> width;
  assign mask = dwhsp_pkg::width_mask(width);
  assign cpos = cnt << width;
  assign cmd_end = (width == dwhsp_pkg::WID_1) ? dwhsp_pkg::CMD_LAST
                                               : last;
  assign word = dwhsp_pkg::cmd_word(cmd, width);
  assign fall = (ph == PH_FALL) && state != M_IDLE && state != M_STOP;
  assign rise = (ph == PH_RISE) && state != M_IDLE && state != M_STOP;
  assign nak_now = state == M_DATA && cnt == 3'h0
                 && ms_s2 == dwhsp_pkg::NAK_LVL;
  assign byte_end = rise && (state == M_TURN
                   || (state == M_DATA && cnt == last && !nak_now));
  assign next_nbytes = (state == M_TURN) ? 4'h0 : nbytes + 4'h1;
  assign more = (next_nbytes != len);
  // Abort on NAK, on the last byte, or when write data is missing
  assign stop = (rise && nak_now)
              || (byte_end && (!more || (is_wr && !wr_valid)));
  assign wr_ready = byte_end && more && is_wr && wr_valid;
  assign req_ready = (state == M_IDLE);

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= M_IDLE;
      ph <= 3'h0;
      cnt <= 3'h0;
      width <= dwhsp_pkg::WID_1;
      cmd <= dwhsp_pkg::CMD_WRITE;
      len <= 4'h0;
      nbytes <= 4'h0;
      sclk_q <= dwhsp_pkg::RESET_SCLK;
      ss_n_q <= dwhsp_pkg::RESET_SS_N;
      done <= 1'b0;
      nak <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      ph <= (ph == PH_END) ? 3'h0 : ph + 3'h1;
      if (fall)
        sclk_q <= 1'b0;
      if (rise)
        sclk_q <= 1'b1;
      unique case (state)
        M_IDLE:
        begin
          if (req_valid)
          begin
            cmd <= req_cmd;
            width <= req_width;
            len <= req_len;
            nak <= 1'b0;
            cnt <= 3'h0;
            ss_n_q <= 1'b0;
            ph <= PH_START;
            state <= M_CMD;
          end
        end
        M_CMD:
        begin
          if (rise)
          begin
            cnt <= cnt + 3'h1;
            if (cnt == cmd_end)
            begin
              cnt <= 3'h0;
              state <= M_TURN;
            end
          end
        end
        M_TURN, M_DATA:
        begin
          if (rise && nak_now)
            nak <= 1'b1;
          if (stop)
            state <= M_STOP;
          else if (byte_end)
          begin
            cnt <= 3'h0;
            nbytes <= next_nbytes;
            state <= M_DATA;
          end
          else if (rise)
            cnt <= cnt + 3'h1;
        end
        M_STOP:
        begin
          if (ph == PH_FALL)
          begin
            ss_n_q <= 1'b1;
            done <= 1'b1;
            state <= M_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_q <= 8'h00;
      oe_q <= 8'h00;
    end
    else if (state == M_STOP)
      // Held past the last edge: the far end samples it a few cycles late
      oe_q <= 8'h00;
    else if (fall && state == M_CMD)
    begin
      // Narrow modes send the word in chunks so spare lines stay pulled up
      out_q <= (word >> cpos) & mask;
      oe_q <= mask;
    end
    else if (fall && state == M_TURN)
      oe_q <= 8'h00;
    else if (fall && state == M_DATA && is_wr)
    begin
      out_q <= sr & mask;
      oe_q <= mask;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sr <= 8'h00;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= 1'b0;
      if (wr_ready)
        sr <= wr_data;
      else if (fall && state == M_DATA && is_wr)
        sr <= dwhsp_pkg::shift_out(sr, width);
      else if (rise && state == M_DATA && is_rd)
      begin
        sr <= dwhsp_pkg::shift_in(sr, md_s2, width);
        if (cnt == last && !nak_now)
        begin
          rd_valid <= 1'b1;
          rd_data <= dwhsp_pkg::shift_in(sr, md_s2, width);
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wbuf_ready <= 1'b0;
      rbuf_ready <= 1'b0;
    end
    else if (state == M_IDLE)
    begin
      wbuf_ready <= (md_s2[0] == dwhsp_pkg::STAT_READY);
      rbuf_ready <= (ms_s2 == dwhsp_pkg::STAT_READY);
    end
  end

  assign link.ss_n = ss_n_q;
  assign link.sclk = sclk_q;
  assign link.m_data_out = out_q;
  assign link.m_data_oe = oe_q;
endmodule

// ### sim/dwhsp_link_asserts.sv
`timescale 1ns/1ps
module dwhsp_link_asserts
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ss_n,
  input wire logic sclk,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic miso,
  input wire logic [7:0] m_data_out,
  input wire logic [7:0] m_data_oe,
  input wire logic [7:0] s_data_out,
  input wire logic [7:0] s_data_oe,
  input wire logic [7:0] bidir_data_lines
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  a_no_line_clash: assert property ((m_data_oe & s_data_oe) == 8'h00)
    else $error("Both ends drive one data line");
  a_select_quiet_start: assert property ($fell(ss_n) |->
    (sclk && m_data_oe == 8'h00) [*3] ##1 !sclk)
    else $error("Master drove lines before first clock fall");
  a_idle_clock_high: assert property (ss_n |-> sclk)
    else $error("Link clock moved while deselected");
  a_idle_master_off: assert property (ss_n |-> m_data_oe == 8'h00)
    else $error("Master still drives lines after deselect");
  a_low_half_period: assert property ($fell(sclk) |-> !sclk [*4] ##1 sclk)
    else $error("Link clock low phase not four cycles");
  a_high_half_period: assert property ($rose(sclk) && !ss_n |-> sclk [*4])
    else $error("Link clock high phase too short");
  a_first_sample_top: assert property ($fell(ss_n) |->
    ##7 ($rose(sclk) && bidir_data_lines[7]))
    else $error("First sample edge late or top line low");
  // Miso may only move in the high half or as the clock falls; the rest of the low half must be quiet
  a_ack_steady_low: assert property (!ss_n && $past(!ss_n) && !sclk
    && !$past(sclk) |-> $stable(miso))
    else $error("Transfer status moved during low clock half");
  a_idle_status_pair: assert property (ss_n && $past(ss_n, 4) |->
    s_data_oe == {7'h00, miso_oe})
    else $error("Idle status drives not paired");

  cover property ($fell(ss_n));
  cover property (!ss_n && miso_oe && miso && $rose(sclk));
  cover property ($rose(ss_n) && s_data_oe[0]);
endmodule

// ### sim/test_dwhsp.sv
`timescale 1ns/1ps
module test_dwhsp;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic status_en = 1'b1;
  logic wr_tready = 1'b0;
  logic [7:0] wr_tdata;
  logic wr_tvalid;
  logic [7:0] rd_tdata = 8'h00;
  logic rd_tvalid = 1'b0;
  logic rd_tready;
  logic req_valid = 1'b0;
  logic req_ready;
  logic [3:0] req_cmd = 4'h0;
  logic [1:0] req_width = 2'h0;
  logic [3:0] req_len = 4'h0;
  logic [7:0] wr_data = 8'h00;
  logic wr_valid = 1'b1;
  logic wr_ready;
  logic [7:0] rd_data;
  logic rd_valid;
  logic done;
  logic nak;
  logic wbuf_ready;
  logic rbuf_ready;
  logic [7:0] exp_r = 8'h00;
  int failures = 0;
  int check_count = 0;
  int rd_cnt = 0;
  int n0;

  dwhsp_link_if link();

  dwhsp_master dwhsp_master_inst (.mclk(mclk), .reset_n(reset_n),
    .link(link), .req_valid(req_valid), .req_ready(req_ready),
    .req_cmd(req_cmd), .req_width(req_width), .req_len(req_len),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .nak(nak),
    .wbuf_ready(wbuf_ready), .rbuf_ready(rbuf_ready));

  dwhsp_slave dwhsp_slave_inst (.mclk(mclk), .reset_n(reset_n),
    .link(link), .status_en(status_en), .wr_tdata(wr_tdata),
    .wr_tvalid(wr_tvalid), .wr_tready(wr_tready), .rd_tdata(rd_tdata),
    .rd_tvalid(rd_tvalid), .rd_tready(rd_tready));

  dwhsp_link_asserts dwhsp_link_asserts_inst (.mclk(mclk),
    .reset_n(reset_n), .ss_n(link.ss_n), .sclk(link.sclk),
    .miso_out(link.miso_out), .miso_oe(link.miso_oe), .miso(link.miso),
    .m_data_out(link.m_data_out), .m_data_oe(link.m_data_oe),
    .s_data_out(link.s_data_out), .s_data_oe(link.s_data_oe),
    .bidir_data_lines(link.bidir_data_lines));

  always #(dwhsp_pkg::MCLK_PERIOD_NS / 2) mclk = ~mclk;

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Data sources advance only when a byte is taken
  always @(posedge mclk)
  begin
    if (rd_tready === 1'b1)
      rd_tdata <= rd_tdata + 8'h11;
    if (wr_ready === 1'b1)
      wr_data <= wr_data + 8'h13;
    if (rd_valid === 1'b1)
    begin
      check(rd_data, exp_r);
      exp_r = exp_r + 8'h11;
      rd_cnt++;
    end
  end

  task automatic xfer(input logic [3:0] c, input logic [1:0] w,
                      input logic [3:0] n);
    int k;
    k = 0;
    req_cmd <= c;
    req_width <= w;
    req_len <= n;
    req_valid <= 1'b1;
    do
    begin
      @(posedge mclk);
      k++;
    end while (req_ready !== 1'b1 && k < 100);
    req_valid <= 1'b0;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end while (done !== 1'b1 && k < 8000);
    check({7'h0, done}, 8'h01);
  endtask

  // Far side stalls during writes, so bytes pile up in the buffer
  task automatic drain(input int n, input logic [7:0] first);
    logic [7:0] e;
    int got;
    int k;
    e = first;
    got = 0;
    k = 0;
    wr_tready <= 1'b1;
    while (got < n && k < 60)
    begin
      @(posedge mclk);
      k++;
      if (wr_tvalid === 1'b1 && wr_tready === 1'b1)
      begin
        check(wr_tdata, e);
        e = e + 8'h13;
        got++;
      end
    end
    wr_tready <= 1'b0;
    check(8'(got), 8'(n));
    @(posedge mclk);
    check({7'h0, wr_tvalid}, 8'h00);
  endtask

  initial
  begin
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (12) @(posedge mclk);
    check({6'h0, wbuf_ready, rbuf_ready}, 8'h02);
    rd_tvalid <= 1'b1;
    repeat (12) @(posedge mclk);
    check({6'h0, wbuf_ready, rbuf_ready}, 8'h03);
    status_en <= 1'b0;
    repeat (12) @(posedge mclk);
    check({6'h0, wbuf_ready, rbuf_ready}, 8'h00);
    status_en <= 1'b1;
    for (int w = 0; w < 4; w++)
    begin
      wr_data <= 8'h5a + 8'(w);
      xfer(dwhsp_pkg::CMD_WRITE, 2'(w), 4'h2);
      check({7'h0, nak}, 8'h00);
      drain(2, 8'h5a + 8'(w));
    end
    wr_data <= 8'h30;
    xfer(dwhsp_pkg::CMD_WRITE, dwhsp_pkg::WID_8, 4'h5);
    check({7'h0, nak}, 8'h01);
    drain(4, 8'h30);
    xfer(4'h5, dwhsp_pkg::WID_1, 4'h1);
    check({7'h0, nak}, 8'h01);
    check({7'h0, wr_tvalid}, 8'h00);
    for (int w = 0; w < 4; w++)
    begin
      rd_tdata <= 8'h21 + 8'(w);
      exp_r = 8'h21 + 8'(w);
      n0 = rd_cnt;
      xfer(dwhsp_pkg::CMD_READ, 2'(w), 4'h3);
      check({7'h0, nak}, 8'h00);
      check(8'(rd_cnt - n0), 8'h03);
    end
    rd_tvalid <= 1'b0;
    repeat (8) @(posedge mclk);
    n0 = rd_cnt;
    xfer(dwhsp_pkg::CMD_READ, dwhsp_pkg::WID_2, 4'h2);
    check({7'h0, nak}, 8'h01);
    check(8'(rd_cnt - n0), 8'h00);
    stop_test();
  end

  initial
  begin
    repeat (50000) @(posedge mclk);
    failures++;
    stop_test();
  end
endmodule
